// File: hw/dcc_regs.vh
`ifndef DCC_REGS_VH
`define DCC_REGS_VH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define DCC_OFS_CLKSEL 8'h00
`define DCC_OFS_TBCTRL 8'h04
`define DCC_OFS_STATUS 8'h08
`define DCC_OFS_TBCOUNT 8'h0c
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DCC_SYSSEL_LO 0
`define DCC_SYSSEL_HI 1
`define DCC_MOSC_EN 2
`define DCC_MOSC_RDY 6
`define DCC_SOSC_RDY 7
`define DCC_TBSRC 0
`define DCC_LCDSEL 1
`define DCC_ST_STOP 0
`define DCC_ST_WAIT 1
`define DCC_ST_HOLD 2
`define DCC_ST_ACTSEL 3
`define DCC_ST_MRUN 5
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DCC_SYSSEL_RST 2'h2
`define DCC_MOSC_EN_RST 1'h1
`define DCC_TBSRC_RST 1'h0
`define DCC_LCDSEL_RST 1'h0
// ---------------------------------------------------------------
// system clock sources
// ---------------------------------------------------------------
`define DCC_SEL_DIV2 2'h0
`define DCC_SEL_DIV4 2'h1
`define DCC_SEL_DIV64 2'h2
`define DCC_SEL_SUB 2'h3
// ---------------------------------------------------------------
// counter presets and counts
// ---------------------------------------------------------------
`define DCC_PRESET 16'h0078
`define DCC_DIV_PRESET 7'h78
`define DCC_POR_PRESET 6'h00
`define DCC_TB_PRESET 14'h0078
`define DCC_TB_READY_COUNT 16'd8072
`define DCC_TAP_DIV2 0
`define DCC_TAP_DIV4 1
`define DCC_TAP_DIV64 5
`define DCC_TAP_DIV128 6
`define DCC_TB_TAP64 5
`define DCC_TB_TAP128 6
`endif

// File: hw/dcc_sync.v
`timescale 1ns/1ps
module dcc_sync (
   clk_sys,
   rst_b,
   pinIn,
   level,
   rise
);
   input wire clk_sys;
   input wire rst_b;
   input wire pinIn;
   output wire level;
   output wire rise;

   // -------------------------------------------------------------
   // two-stage synchroniser plus edge history
   // -------------------------------------------------------------
   // the first stage feeds only the second; edges use later stages
   reg meta;
   reg stable;
   reg prev;

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta <= 1'b0;
         stable <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pinIn;
         stable <= meta;
         prev <= stable;
      end
   end

   assign level = stable;
   assign rise = stable & ~prev;
endmodule // dcc_sync

// File: hw/dcc_clock_control.v
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dcc_regs.vh"
module dcc_clock_control (
   clk_sys,
   rst_b,
   primaryCrystalClock,
   secondaryCrystalClock,
   extResetPin,
   extInterruptOne,
   extInterruptTwo,
   keyboardWake,
   simpleSerialPort,
   timebaseInterrupt,
   anyInterrupt,
   stopReq,
   waitReq,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hrdata,
   hreadyout,
   hresp,
   mainOscRun,
   sysClk,
   cpuClk,
   periphClk,
   internalReset,
   displayDriverClock,
   stopMode,
   waitMode
);
   input wire clk_sys;
   input wire rst_b;
   input wire primaryCrystalClock;
   input wire secondaryCrystalClock;
   input wire extResetPin;
   input wire extInterruptOne;
   input wire extInterruptTwo;
   input wire keyboardWake;
   input wire simpleSerialPort;
   input wire timebaseInterrupt;
   input wire anyInterrupt;
   input wire stopReq;
   input wire waitReq;
   input wire hsel;
   input wire [31:0] haddr;
   input wire [1:0] htrans;
   input wire hwrite;
   input wire [2:0] hsize;
   input wire [31:0] hwdata;
   input wire hready;
   output reg [31:0] hrdata;
   output reg hreadyout;
   output reg hresp;
   output reg mainOscRun;
   output reg sysClk;
   output reg cpuClk;
   output reg periphClk;
   output reg internalReset;
   output reg displayDriverClock;
   output reg stopMode;
   output reg waitMode;

   // -------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------
   wire primRise;
   wire secRise;
   wire extRst;
   wire irqOneRise;
   wire irqTwoRise;
   wire kbdRise;
   wire serRise;

   dcc_sync u_syncPrim (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(primaryCrystalClock),
      .level(), .rise(primRise));
   dcc_sync u_syncSec (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(secondaryCrystalClock),
      .level(), .rise(secRise));
   dcc_sync u_syncRst (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(extResetPin),
      .level(extRst), .rise());
   dcc_sync u_syncIrqOne (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(extInterruptOne),
      .level(), .rise(irqOneRise));
   dcc_sync u_syncIrqTwo (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(extInterruptTwo),
      .level(), .rise(irqTwoRise));
   dcc_sync u_syncKbd (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(keyboardWake),
      .level(), .rise(kbdRise));
   dcc_sync u_syncSer (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(simpleSerialPort),
      .level(), .rise(serRise));

   // -------------------------------------------------------------
   // control state
   // -------------------------------------------------------------
   reg [1:0] sysclkSel;
   reg [1:0] activeSel;
   reg mainOscEnable;
   reg mainOscReady;
   reg subOscReady;
   reg timebaseSrcSel;
   reg tbSrcWritten;
   reg lcdClkSel;
   reg [6:0] divCnt;
   reg [5:0] porCnt;
   reg [13:0] tbCnt;
   reg subDiv;
   reg cpuHold;
   reg busWrite;
   reg [7:0] busAddr;

   // -------------------------------------------------------------
   // oscillator edges as enables
   // -------------------------------------------------------------
   // stopped oscillator: pin edges are ignored, not counted
   wire oscRun = mainOscEnable & ~stopMode;
   wire primTick = primRise & oscRun;
   wire div128Tick = primTick & (divCnt == 7'h7f);
   wire porOverflow = div128Tick & (porCnt == 6'h3f);
   wire tbTick = timebaseSrcSel ? div128Tick : secRise;
   wire [15:0] tbTarget = `DCC_PRESET + `DCC_TB_READY_COUNT - 16'd1;
   wire wakeStop = extRst | irqOneRise | irqTwoRise | kbdRise | serRise
      | timebaseInterrupt;
   wire wakeWait = extRst | anyInterrupt;
   wire mainSel = (sysclkSel != `DCC_SEL_SUB);

   // -------------------------------------------------------------
   // main divider and stabilisation counter
   // -------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         divCnt <= `DCC_DIV_PRESET;
         porCnt <= `DCC_POR_PRESET;
      end else if (!mainOscEnable) begin
         divCnt <= `DCC_DIV_PRESET;
         porCnt <= `DCC_POR_PRESET;
      end else if (stopReq && !stopMode) begin
         porCnt <= 6'h00;
      end else if (primTick) begin
         divCnt <= divCnt + 7'h01;
         if (div128Tick) begin
            porCnt <= porCnt + 6'h01;
         end
      end
   end

   // -------------------------------------------------------------
   // ready flags
   // -------------------------------------------------------------
   // external reset leaves both flags alone; power-on clears both, main disable or stop entry clears mainOscReady unless porOverflow sets it that cycle
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mainOscReady <= 1'b0;
      end else if (porOverflow) begin
         mainOscReady <= 1'b1;
      end else if (!mainOscEnable || (stopReq && !stopMode)) begin
         mainOscReady <= 1'b0;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tbCnt <= `DCC_TB_PRESET;
         subOscReady <= 1'b0;
      end else if (tbTick) begin
         tbCnt <= tbCnt + 14'h0001;
         if ({2'b00, tbCnt} == tbTarget) begin
            subOscReady <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // sub oscillator divide by two
   // -------------------------------------------------------------
   // never halted; stop only disconnects it from the system clock
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         subDiv <= 1'b0;
      end else if (secRise) begin
         subDiv <= ~subDiv;
      end
   end

   // -------------------------------------------------------------
   // stop and wait mode sequencing
   // -------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stopMode <= 1'b0;
         waitMode <= 1'b0;
         cpuHold <= 1'b1;
      end else begin
         if (stopMode) begin
            if (wakeStop) begin
               stopMode <= 1'b0;
               // main source must restabilise; sub source resumes now
               cpuHold <= extRst | (mainSel & mainOscEnable);
            end
         end else if (stopReq) begin
            stopMode <= 1'b1;
            waitMode <= 1'b0;
         end else if (waitMode) begin
            if (wakeWait) begin
               waitMode <= 1'b0;
            end
         end else if (waitReq) begin
            waitMode <= 1'b1;
         end
         if (porOverflow) begin
            cpuHold <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // glitch-free source switch and clock outputs
   // -------------------------------------------------------------
   reg activeTap;
   reg pendTap;
   // reopens only on a low tap, so a wake never starts with a runt
   reg clkOn;

   always @* begin
      case (activeSel)
         `DCC_SEL_DIV2: activeTap = divCnt[`DCC_TAP_DIV2];
         `DCC_SEL_DIV4: activeTap = divCnt[`DCC_TAP_DIV4];
         `DCC_SEL_DIV64: activeTap = divCnt[`DCC_TAP_DIV64];
         default: activeTap = subDiv;
      endcase
      case (sysclkSel)
         `DCC_SEL_DIV2: pendTap = divCnt[`DCC_TAP_DIV2];
         `DCC_SEL_DIV4: pendTap = divCnt[`DCC_TAP_DIV4];
         `DCC_SEL_DIV64: pendTap = divCnt[`DCC_TAP_DIV64];
         default: pendTap = subDiv;
      endcase
   end

   // switch only while old and new clocks are both low, so no runt
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         activeSel <= `DCC_SEL_DIV64;
      end else if (activeSel != sysclkSel && !sysClk && !activeTap && !pendTap) begin
         activeSel <= sysclkSel;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sysClk <= 1'b0;
         clkOn <= 1'b0;
         cpuClk <= 1'b0;
         periphClk <= 1'b0;
         mainOscRun <= 1'b0;
         internalReset <= 1'b1;
         displayDriverClock <= 1'b0;
      end else begin
         clkOn <= ~stopMode & (clkOn | ~activeTap);
         sysClk <= activeTap & clkOn & ~stopMode;
         cpuClk <= activeTap & clkOn & ~stopMode & ~waitMode & ~cpuHold;
         periphClk <= activeTap & clkOn & ~stopMode & ~cpuHold;
         mainOscRun <= oscRun;
         internalReset <= cpuHold | extRst;
         displayDriverClock <= lcdClkSel ? tbCnt[`DCC_TB_TAP128]
            : tbCnt[`DCC_TB_TAP64];
      end
   end

   // -------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // -------------------------------------------------------------
   wire addrPhase = hsel & htrans[1] & hready;
   reg [31:0] next_hrdata;

   always @* begin
      next_hrdata = 32'h00000000;
      case (haddr[7:0])
         `DCC_OFS_CLKSEL: begin
            next_hrdata[`DCC_SYSSEL_HI:`DCC_SYSSEL_LO] = sysclkSel;
            next_hrdata[`DCC_MOSC_EN] = mainOscEnable;
            next_hrdata[`DCC_MOSC_RDY] = mainOscReady;
            next_hrdata[`DCC_SOSC_RDY] = subOscReady;
         end
         `DCC_OFS_TBCTRL: begin
            next_hrdata[`DCC_TBSRC] = timebaseSrcSel;
            next_hrdata[`DCC_LCDSEL] = lcdClkSel;
         end
         `DCC_OFS_STATUS: begin
            next_hrdata[`DCC_ST_STOP] = stopMode;
            next_hrdata[`DCC_ST_WAIT] = waitMode;
            next_hrdata[`DCC_ST_HOLD] = cpuHold;
            next_hrdata[`DCC_ST_ACTSEL +: 2] = activeSel;
            next_hrdata[`DCC_ST_MRUN] = oscRun;
         end
         `DCC_OFS_TBCOUNT: next_hrdata[13:0] = tbCnt;
         default: next_hrdata = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         busWrite <= 1'b0;
         busAddr <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         busWrite <= addrPhase & hwrite;
         busAddr <= haddr[7:0];
         if (addrPhase && !hwrite) begin
            hrdata <= next_hrdata;
         end
      end
   end

   // -------------------------------------------------------------
   // software registers
   // -------------------------------------------------------------
   // software must honour the ready flags before switching source;
   // the hardware does not refuse an early switch
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sysclkSel <= `DCC_SYSSEL_RST;
         mainOscEnable <= `DCC_MOSC_EN_RST;
         timebaseSrcSel <= `DCC_TBSRC_RST;
         tbSrcWritten <= 1'b0;
         lcdClkSel <= `DCC_LCDSEL_RST;
      end else if (extRst) begin
         sysclkSel <= `DCC_SYSSEL_RST;
         mainOscEnable <= `DCC_MOSC_EN_RST;
         timebaseSrcSel <= `DCC_TBSRC_RST;
         tbSrcWritten <= 1'b0;
         lcdClkSel <= `DCC_LCDSEL_RST;
      end else if (busWrite) begin
         case (busAddr)
            `DCC_OFS_CLKSEL: begin
               sysclkSel <= hwdata[`DCC_SYSSEL_HI:`DCC_SYSSEL_LO];
               mainOscEnable <= hwdata[`DCC_MOSC_EN];
            end
            `DCC_OFS_TBCTRL: begin
               lcdClkSel <= hwdata[`DCC_LCDSEL];
               if (!tbSrcWritten) begin
                  timebaseSrcSel <= hwdata[`DCC_TBSRC];
                  tbSrcWritten <= 1'b1;
               end
            end
            default: tbSrcWritten <= tbSrcWritten;
         endcase
      end
   end
endmodule // dcc_clock_control

// File: tb/dcc_clock_control_properties.sv
`timescale 1ns/1ps
module dcc_clock_control_properties (
   input wire clk_sys,
   input wire rst_b,
   input wire stopReq,
   input wire anyInterrupt,
   input wire timebaseInterrupt,
   input wire extInterruptOne,
   input wire mainOscRun,
   input wire sysClk,
   input wire cpuClk,
   input wire internalReset,
   input wire stopMode,
   input wire waitMode
);
   // ------------------------------------------------------------
   // mode and clock gating checks
   // ------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence stop_taken;
      stopReq && !stopMode ##1 stopMode;
   endsequence
   sequence clk_up;
      !sysClk ##1 sysClk;
   endsequence
   // a forced stop may cut the last high phase, so stop is let through
   chk_clk_high: assert property (clk_up |=> sysClk || stopMode)
      else $error("system clock high phase too short");
   chk_clk_low: assert property (sysClk ##1 !sysClk |=> !sysClk)
      else $error("system clock low phase too short");
   chk_release_hold: assert property ($rose(rst_b) |-> internalReset)
      else $error("no hold after power-on release");
   chk_stop_entry: assert property (stopReq && !stopMode |=> stopMode)
      else $error("stop not entered");
   chk_osc_halt: assert property (stop_taken |-> ##[0:1] !mainOscRun)
      else $error("main oscillator still running in stop");
   chk_stop_gates: assert property (stopMode [*2] |-> !sysClk && !cpuClk)
      else $error("clock running in stop");
   chk_wait_cpu: assert property (waitMode [*2] |-> !cpuClk)
      else $error("cpu clock running in wait");
   chk_wait_exit: assert property (waitMode && anyInterrupt |-> ##[1:3] !waitMode)
      else $error("wait not left on interrupt");
   chk_tb_wake: assert property (stopMode && timebaseInterrupt |-> ##[1:3] !stopMode)
      else $error("stop not left on timebase wake");
   chk_irq_wake: assert property (stopMode && $rose(extInterruptOne) |-> ##[1:8] !stopMode)
      else $error("stop not left on interrupt line");
endmodule // dcc_clock_control_properties

bind dcc_clock_control dcc_clock_control_properties i_props (
   .clk_sys,
   .rst_b,
   .stopReq,
   .anyInterrupt,
   .timebaseInterrupt,
   .extInterruptOne,
   .mainOscRun,
   .sysClk,
   .cpuClk,
   .internalReset,
   .stopMode,
   .waitMode
);

// File: tb/dcc_clock_control_test.sv
`timescale 1ns/1ps
`include "dcc_regs.vh"
module dcc_clock_control_test;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] ph = 2'h0;
   // wake lines 4:0, stop 5, wait 6, any interrupt 7, external reset 8
   logic [8:0] ev = 9'h000;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] r;
   wire [31:0] hrdata;
   wire hreadyout, hresp, mainOscRun, sysClk, cpuClk, periphClk;
   wire internalReset, displayDriverClock, stopMode, waitMode;
   wire [3:0] clks = {displayDriverClock, periphClk, cpuClk, sysClk};
   wire [3:0] flag = {mainOscRun, waitMode, stopMode, internalReset};
   int n_fail = 0;
   int checked = 0;
   int d;
   int rate [4] = '{128, 64, 4, 128};
   time t0;

   always #50 clk_sys = ~clk_sys;
   // both crystals at 2.5 MHz: the pins are sampled, so faster would alias
   always @(posedge clk_sys) ph <= ph + 2'h1;

   dcc_clock_control i_dut (
      .clk_sys,
      .rst_b,
      .primaryCrystalClock(ph[1]),
      .secondaryCrystalClock(ph[1]),
      .extResetPin(ev[8]),
      .extInterruptOne(ev[0]),
      .extInterruptTwo(ev[1]),
      .keyboardWake(ev[2]),
      .simpleSerialPort(ev[3]),
      .timebaseInterrupt(ev[4]),
      .anyInterrupt(ev[7]),
      .stopReq(ev[5]),
      .waitReq(ev[6]),
      .hsel,
      .haddr,
      .htrans,
      .hwrite,
      .hsize(3'h2),
      .hwdata,
      .hready(hreadyout),
      .hrdata,
      .hreadyout,
      .hresp,
      .mainOscRun,
      .sysClk,
      .cpuClk,
      .periphClk,
      .internalReset,
      .displayDriverClock,
      .stopMode,
      .waitMode
   );

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic test_done;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= dat;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(r & m, e);
   endtask

   task automatic hit(input int k, input int len);
      @(posedge clk_sys);
      ev[k] <= 1'b1;
      repeat (len) @(posedge clk_sys);
      ev[k] <= 1'b0;
   endtask

   task automatic wt(input int k, input logic v, input int lim);
      for (int i = 0; i < lim && flag[k] !== v; i++) @(posedge clk_sys);
      chk(32'(flag[k]), 32'(v));
   endtask

   // counts rising edges; one edge of slack for phase
   task automatic cnt(input int k, input int len, input int e);
      int c;
      logic p;
      c = 0;
      p = clks[k];
      repeat (len) begin
         @(posedge clk_sys);
         if (clks[k] === 1'b1 && p === 1'b0) c++;
         p = clks[k];
      end
      chk(32'(c >= e - 1 && c <= e + 1), 32'h1);
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      t0 = $time;
      @(posedge clk_sys);
      @(posedge clk_sys);
      chk(32'(internalReset), 32'h1);
      rc(`DCC_OFS_CLKSEL, 32'hc7, 32'h06);
      rc(`DCC_OFS_TBCTRL, 32'h3, 32'h0);
      wt(0, 1'b0, 40000);
      d = int'(($time - t0) / 100) - 8072 * 4;
      chk(32'(d > -10 && d < 20), 32'h1);
      rc(`DCC_OFS_CLKSEL, 32'h40, 32'h40);
      do bus(1'b0, `DCC_OFS_CLKSEL, 32'h0); while (r[7] !== 1'b1);
      d = int'(($time - t0) / 100) - 8072 * 4;
      chk(32'(d > -10 && d < 40), 32'h1);
      $display("startup done");
      bus(1'b1, `DCC_OFS_CLKSEL, 32'h4);
      hit(5, 1);
      wt(1, 1'b1, 4);
      rc(`DCC_OFS_CLKSEL, 32'h40, 32'h0);
      t0 = $time;
      hit(8, 4);
      wt(0, 1'b1, 8);
      wt(0, 1'b0, 40000);
      d = int'(($time - t0) / 100);
      chk(32'(d > 8064 * 4 - 8 && d < 8192 * 4 + 20), 32'h1);
      rc(`DCC_OFS_CLKSEL, 32'hc7, 32'hc6);
      $display("main source stop done");
      bus(1'b1, `DCC_OFS_TBCTRL, 32'h2);
      cnt(3, 1024, 2);
      bus(1'b1, `DCC_OFS_TBCTRL, 32'h1);
      rc(`DCC_OFS_TBCTRL, 32'h3, 32'h0);
      cnt(3, 1024, 4);
      bus(1'b1, 8'h20, 32'hffffffff);
      rc(8'h20, 32'hffffffff, 32'h0);
      $display("timebase done");
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, `DCC_OFS_CLKSEL, 32'h4 | s);
         rc(`DCC_OFS_CLKSEL, 32'h7, 32'h4 | s);
         do bus(1'b0, `DCC_OFS_STATUS, 32'h0); while (r[4:3] !== s[1:0]);
         cnt(0, 1024, rate[s]);
      end
      $display("source select done");
      hit(6, 1);
      wt(2, 1'b1, 4);
      cnt(1, 256, 0);
      cnt(2, 256, 32);
      hit(7, 1);
      wt(2, 1'b0, 8);
      $display("wait done");
      for (int w = 0; w < 5; w++) begin
         hit(5, 1);
         wt(1, 1'b1, 4);
         wt(3, 1'b0, 4);
         cnt(0, 64, 0);
         hit(w, 4);
         wt(1, 1'b0, 12);
         chk(32'(internalReset), 32'h0);
         wt(3, 1'b1, 4);
      end
      rc(`DCC_OFS_CLKSEL, 32'h40, 32'h0);
      $display("sub source stop done");
      bus(1'b1, `DCC_OFS_CLKSEL, 32'h3);
      wt(3, 1'b0, 4);
      hit(5, 1);
      wt(1, 1'b1, 4);
      hit(0, 4);
      wt(1, 1'b0, 12);
      cnt(1, 64, 8);
      chk(32'(mainOscRun), 32'h0);
      bus(1'b1, `DCC_OFS_CLKSEL, 32'h7);
      wt(3, 1'b1, 4);
      rc(`DCC_OFS_CLKSEL, 32'h40, 32'h0);
      $display("disable done");
      test_done;
   end

   // the tests need about 75000 cycles; this cuts a hang
   initial begin
      #9_000_000;
      n_fail++;
      test_done;
   end
endmodule // dcc_clock_control_test
